// >>> logic/spi_pkg.sv
// spi_pkg: register map, field positions and state record of the spi block
// assumes a 16-bit register port addressed by full 32-bit byte addresses
package spi_pkg;
  localparam logic [31:0] addr_status = 32'h4000_4000;
  localparam logic [31:0] addr_rx     = 32'h4000_4004;
  localparam logic [31:0] addr_tx     = 32'h4000_4008;
  localparam logic [31:0] addr_div    = 32'h4000_400c;
  localparam logic [31:0] addr_cfg    = 32'h4000_4010;

  localparam int st_irq      = 0;
  localparam int st_fill_lo  = 1;
  localparam int st_fill_hi  = 3;
  localparam int st_underrun = 4;
  localparam int st_rx_lo    = 8;
  localparam int st_rx_hi    = 10;
  localparam int st_cs_abort = 12;

  localparam int cfg_enable = 0;
  localparam int cfg_master = 1;
  localparam int cfg_flush  = 13;

  localparam int div_abort_reset = 7;
  localparam int div_hi          = 5;
  localparam int byte_msb        = 7;

  localparam logic [7:0] div_write_mask = 8'hbf;
  localparam logic [2:0] fifo_full      = 3'h4;
  localparam logic [3:0] last_bit       = 4'h7;

  typedef enum logic {ph_idle, ph_shift} phase_t;

  typedef struct packed {
    logic [31:0] addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } reg_req_t;

  typedef struct packed {
    logic sclk;
    logic cs_n;
    logic din;
  } pin_in_t;

  typedef struct packed {
    logic sclk;
    logic sclk_oe;
    logic cs_n;
    logic cs_n_oe;
    logic dout;
    logic dout_oe;
  } pin_out_t;

  typedef struct packed {
    logic [15:0]     cfg;
    logic [7:0]      divr;
    logic [3:0][7:0] txq;
    logic [1:0]      tx_rd;
    logic [1:0]      tx_wr;
    logic [2:0]      tx_cnt;
    logic [3:0][7:0] rxq;
    logic [1:0]      rx_rd;
    logic [1:0]      rx_wr;
    logic [2:0]      rx_cnt;
    logic [7:0]      shreg;
    logic            sh_valid;
    logic [7:0]      rx_sample;
    logic [3:0]      bit_cnt;
    phase_t          phase;
    logic [5:0]      half_cnt;
    logic            sclk_prev;
    logic            cs_prev;
    logic            underrun;
    logic            cs_abort;
    logic            irq;
    logic [15:0]     rdata;
    pin_out_t        pin;
  } spi_state_t;

  localparam spi_state_t state_reset = '{
    pin: '{cs_n: 1'b1, default: 1'b0},
    phase: ph_idle,
    cs_prev: 1'b1,
    sclk_prev: 1'b0,
    default: '0
  };
endpackage

// >>> logic/spi_fifo_status_and_baud.sv
// spi_fifo_status_and_baud: spi byte fifos, status, baud divider, cs abort
// assumes synchronous pin inputs, mclk as divider source, mode 0 framing
//
// Notes on behaviour
// - underrun flag when transfer starts empty
// - status read clears underrun flag
// - tx fill level in status bits 3:1
// - master: count drops when byte leaves fifo
// - slave: count drops after byte shifted out
// - slave: count includes byte in shifter
// - master sends loaded byte at once
// - summary flag on abort, or on underrun with flush off, read clears
// - rx read pops byte, empty gives zero
// - tx write fills slot, full overwrites oldest
// - tx address reads zero, fifo untouched
// - abort option 0: resume remaining bits
// - abort option 1: reset interface logic
// - master clock is mclk/(2*(1+div))
// - slave ignores divider, uses master clock
// - flush enable control, zero disables flushing
// - cs abort flag on early deselect
`timescale 1ns/10ps
module spi_fifo_status_and_baud (
  input  wire logic              mclk,
  input  wire logic              resetn,
  input  wire spi_pkg::reg_req_t req,
  output logic [15:0]            rdata,
  input  wire spi_pkg::pin_in_t  pin_in,
  output spi_pkg::pin_out_t      pin_out
);
  spi_pkg::spi_state_t s;
  spi_pkg::spi_state_t n;
  logic        en;
  logic        master;
  logic        flush;
  logic        abort_reset;
  logic [5:0]  div;
  logic        sclk_rise;
  logic        sclk_fall;
  logic        cs_fall;
  logic        cs_rise;
  logic        rd_status;
  logic        tx_push;
  logic        rx_pop;
  logic [2:0]  tx_total;
  logic [2:0]  fill_level;
  logic        tx_pop;
  logic        rx_push;
  logic        byte_done;
  logic        bit_rise;
  logic        bit_fall;
  logic        set_underrun;
  logic        set_abort;
  logic        set_irq;
  logic [2:0]  tx_left;
  logic [1:0]  tx_rd_next;
  logic [2:0]  rx_left;
  logic [15:0] status_word;

  function automatic logic hit(input logic        strobe,
                               input logic [31:0] addr,
                               input logic [31:0] target);
    return strobe && (addr == target);
  endfunction

  assign en          = s.cfg[spi_pkg::cfg_enable];
  assign master      = s.cfg[spi_pkg::cfg_master];
  assign flush       = s.cfg[spi_pkg::cfg_flush];
  assign abort_reset = s.divr[spi_pkg::div_abort_reset];
  assign div         = s.divr[spi_pkg::div_hi:0];
  assign sclk_rise   = pin_in.sclk & ~s.sclk_prev;
  assign sclk_fall   = ~pin_in.sclk & s.sclk_prev;
  assign cs_fall     = ~pin_in.cs_n & s.cs_prev;
  assign cs_rise     = pin_in.cs_n & ~s.cs_prev;
  assign rd_status   = hit(req.rd, req.addr, spi_pkg::addr_status);
  assign tx_push     = hit(req.wr, req.addr, spi_pkg::addr_tx);
  assign rx_pop      = hit(req.rd, req.addr, spi_pkg::addr_rx)
                       && (s.rx_cnt != '0);
  // slave counts the byte parked in the shifter as well
  assign tx_total    = s.tx_cnt + {2'h0, s.sh_valid & ~master};
  assign fill_level  = (tx_total > spi_pkg::fifo_full) ?
                       spi_pkg::fifo_full : tx_total;

  always_comb begin
    n            = s;
    tx_pop       = 1'b0;
    byte_done    = 1'b0;
    bit_rise     = 1'b0;
    bit_fall     = 1'b0;
    set_underrun = 1'b0;
    set_abort    = 1'b0;
    n.sclk_prev  = pin_in.sclk;
    n.cs_prev    = pin_in.cs_n;
    n.pin.sclk_oe = en & master;
    n.pin.cs_n_oe = en & master;

    if (!en) begin
      n.phase       = spi_pkg::ph_idle;
      n.half_cnt    = '0;
      n.pin.sclk    = 1'b0;
      n.pin.cs_n    = 1'b1;
      n.pin.dout_oe = 1'b0;
    end else if (master) begin
      n.pin.dout_oe = 1'b1;
      case (s.phase)
        spi_pkg::ph_idle: begin
          if (s.tx_cnt != '0 && !flush) begin
            // fifo count drops as the byte enters the shifter
            tx_pop     = 1'b1;
            n.shreg    = s.txq[s.tx_rd];
            n.pin.dout = s.txq[s.tx_rd][spi_pkg::byte_msb];
            n.pin.cs_n = 1'b0;
            n.phase    = spi_pkg::ph_shift;
            n.bit_cnt  = '0;
            n.half_cnt = '0;
            n.pin.sclk = 1'b0;
          end else begin
            n.pin.cs_n = 1'b1;
          end
        end
        spi_pkg::ph_shift: begin
          if (s.half_cnt < div) begin
            n.half_cnt = s.half_cnt + 6'h01;
          end else begin
            n.half_cnt = '0;
            n.pin.sclk = ~s.pin.sclk;
            bit_rise   = ~s.pin.sclk;
            bit_fall   = s.pin.sclk;
          end
        end
        default: begin
          n.phase = spi_pkg::ph_idle;
        end
      endcase
    end else begin
      // slave: clock comes from the far master, divider unused
      n.pin.sclk    = 1'b0;
      n.pin.cs_n    = 1'b1;
      n.pin.dout_oe = ~pin_in.cs_n;
      n.half_cnt    = '0;
      if (s.phase == spi_pkg::ph_idle && pin_in.cs_n && !s.sh_valid
          && s.bit_cnt == '0 && s.tx_cnt != '0 && !flush) begin
        // byte waits in the shifter for the far master
        tx_pop     = 1'b1;
        n.shreg    = s.txq[s.tx_rd];
        n.sh_valid = 1'b1;
        n.pin.dout = s.txq[s.tx_rd][spi_pkg::byte_msb];
      end
      if (cs_fall && s.phase == spi_pkg::ph_idle) begin
        n.phase = spi_pkg::ph_shift;
        if (!s.sh_valid && s.bit_cnt == '0) begin
          set_underrun = 1'b1;
          n.shreg      = '0;
          n.pin.dout   = 1'b0;
        end
      end
      if (s.phase == spi_pkg::ph_shift) begin
        if (cs_rise) begin
          set_abort = 1'b1;
          n.phase   = spi_pkg::ph_idle;
          if (abort_reset) begin
            n.bit_cnt   = '0;
            n.sh_valid  = 1'b0;
            n.rx_sample = '0;
          end
        end else begin
          bit_rise = sclk_rise;
          bit_fall = sclk_fall;
        end
      end
    end

    // sample on the rising edge, shift on the falling edge
    if (bit_rise) begin
      n.rx_sample = {s.rx_sample[6:0], pin_in.din};
    end
    if (bit_fall) begin
      if (s.bit_cnt == spi_pkg::last_bit) begin
        byte_done = 1'b1;
        n.bit_cnt = '0;
        n.phase   = spi_pkg::ph_idle;
        if (!master) begin
          n.sh_valid = 1'b0;
        end
      end else begin
        n.bit_cnt  = s.bit_cnt + 4'h1;
        n.shreg    = {s.shreg[6:0], 1'b0};
        n.pin.dout = s.shreg[6];
      end
    end
    rx_push = byte_done;

    // sticky flags: a set in the clearing cycle wins
    set_irq    = (set_underrun & ~flush) | set_abort;
    n.underrun = (s.underrun & ~rd_status) | set_underrun;
    n.cs_abort = (s.cs_abort & ~rd_status) | set_abort;
    n.irq      = (s.irq & ~rd_status) | set_irq;

    tx_left    = s.tx_cnt - {2'h0, tx_pop};
    tx_rd_next = s.tx_rd + {1'b0, tx_pop};
    if (tx_push) begin
      n.txq[s.tx_wr] = req.wdata[spi_pkg::byte_msb:0];
      n.tx_wr        = s.tx_wr + 2'h1;
      if (tx_left == spi_pkg::fifo_full) begin
        tx_rd_next = tx_rd_next + 2'h1;
      end else begin
        tx_left = tx_left + 3'h1;
      end
    end
    n.tx_rd  = tx_rd_next;
    n.tx_cnt = tx_left;
    if (flush) begin
      n.tx_cnt = '0;
      n.tx_rd  = n.tx_wr;
    end

    rx_left = s.rx_cnt - {2'h0, rx_pop};
    n.rx_rd = s.rx_rd + {1'b0, rx_pop};
    if (rx_push && rx_left != spi_pkg::fifo_full) begin
      n.rxq[s.rx_wr] = s.rx_sample;
      n.rx_wr        = s.rx_wr + 2'h1;
      rx_left        = rx_left + 3'h1;
    end
    n.rx_cnt = rx_left;

    status_word = '0;
    status_word[spi_pkg::st_irq] = s.irq;
    status_word[spi_pkg::st_fill_hi:spi_pkg::st_fill_lo] = fill_level;
    status_word[spi_pkg::st_underrun] = s.underrun;
    status_word[spi_pkg::st_rx_hi:spi_pkg::st_rx_lo] = s.rx_cnt;
    status_word[spi_pkg::st_cs_abort] = s.cs_abort;

    n.rdata = '0;
    if (req.rd) begin
      case (req.addr)
        spi_pkg::addr_status: n.rdata = status_word;
        spi_pkg::addr_rx:     n.rdata = rx_pop ?
                                {8'h00, s.rxq[s.rx_rd]} : '0;
        spi_pkg::addr_div:    n.rdata = {8'h00, s.divr};
        spi_pkg::addr_cfg:    n.rdata = s.cfg;
        default:              n.rdata = '0;
      endcase
    end
    if (hit(req.wr, req.addr, spi_pkg::addr_div)) begin
      n.divr = req.wdata[7:0] & spi_pkg::div_write_mask;
    end
    if (hit(req.wr, req.addr, spi_pkg::addr_cfg)) begin
      n.cfg = req.wdata;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      s <= spi_pkg::state_reset;
    end else begin
      s <= n;
    end
  end

  assign rdata   = s.rdata;
  assign pin_out = s.pin;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!resetn);

  sequence master_load;
    en && master && s.phase == spi_pkg::ph_idle && s.tx_cnt != '0 && !flush;
  endsequence
  sequence shift_started;
    s.phase == spi_pkg::ph_shift && !s.pin.cs_n && !s.pin.sclk;
  endsequence
  sequence slave_start;
    en && !master && cs_fall && s.phase == spi_pkg::ph_idle
    && s.bit_cnt == '0;
  endsequence
  sequence slave_abort;
    en && !master && s.phase == spi_pkg::ph_shift && cs_rise;
  endsequence

  a_underrun_set: assert property (
    (slave_start and (!s.sh_valid)) |=> s.underrun && (s.irq || $past(flush)))
    else $error("underrun not flagged on empty start");
  a_status_clear: assert property (
    rd_status && !set_underrun |=> !s.underrun)
    else $error("underrun not cleared by status read");
  a_fill_report: assert property (
    rd_status |=> s.rdata[spi_pkg::st_fill_hi:spi_pkg::st_fill_lo]
                  == $past(fill_level))
    else $error("status fill level wrong");
  a_master_pop: assert property (
    (master_load and (!tx_push)) |=> s.tx_cnt == $past(s.tx_cnt) - 3'h1)
    else $error("master load did not drop count");
  a_slave_count: assert property (
    en && !master && !byte_done && !tx_push && !flush && !set_abort
    && !req.wr |=> $stable(fill_level))
    else $error("slave fill changed without cause");
  a_master_start: assert property (
    master_load and (!req.wr) |=> shift_started)
    else $error("loaded byte not sent at once");
  a_irq_summary: assert property (
    set_irq |=> s.irq ##1 (s.irq || $past(rd_status)))
    else $error("summary flag not set");
  a_rx_empty: assert property (
    hit(req.rd, req.addr, spi_pkg::addr_rx) && s.rx_cnt == '0
    |=> s.rdata == '0)
    else $error("empty rx read not zero");
  a_tx_overwrite: assert property (
    tx_push && s.tx_cnt == spi_pkg::fifo_full && !tx_pop && !flush
    |=> s.tx_cnt == spi_pkg::fifo_full && s.tx_rd == $past(s.tx_rd) + 2'h1)
    else $error("full tx write did not drop oldest");
  a_tx_read_zero: assert property (
    hit(req.rd, req.addr, spi_pkg::addr_tx) |=> s.rdata == '0)
    else $error("tx address read not zero");
  a_abort_resume: assert property (
    slave_abort and (!abort_reset) |=> s.bit_cnt == $past(s.bit_cnt)
                                       && s.phase == spi_pkg::ph_idle)
    else $error("abort lost bit position");
  a_abort_reset: assert property (
    slave_abort and abort_reset |=> s.bit_cnt == '0 && !s.sh_valid)
    else $error("abort did not reset interface");
  a_baud_hold: assert property (
    en && master && s.phase == spi_pkg::ph_shift && s.half_cnt < div
    |=> $stable(s.pin.sclk) && s.half_cnt == $past(s.half_cnt) + 6'h01)
    else $error("serial clock toggled early");
  a_baud_flip: assert property (
    en && master && s.phase == spi_pkg::ph_shift && s.half_cnt >= div
    |=> $changed(s.pin.sclk) && s.half_cnt == '0)
    else $error("serial clock did not toggle");
  a_slave_clock: assert property (
    en && !master |=> !s.pin.sclk_oe && !s.pin.sclk)
    else $error("slave drove serial clock");
  a_flush_empty: assert property (
    flush |=> s.tx_cnt == '0)
    else $error("flush left bytes in tx fifo");
  a_abort_flag: assert property (
    slave_abort |=> s.cs_abort && s.irq)
    else $error("cs abort not flagged");
  a_read_first: assert property (
    rd_status |=> s.rdata[spi_pkg::st_underrun] == $past(s.underrun)
                  && s.rdata[spi_pkg::st_irq] == $past(s.irq))
    else $error("status read did not show old flags");
endmodule

// >>> tb/spi_peer_model.sv
// spi_peer_model: far-side spi device, slave to the block or its master
// assumes mode 0 framing, msb first, the block's pins sampled on mclk
`timescale 1ns/10ps
module spi_peer_model (
  input  wire logic              mclk,
  input  wire logic [7:0]        send_byte,
  input  wire spi_pkg::pin_out_t pin_out,
  output spi_pkg::pin_in_t       pin_in
);
  logic       m_mode = 1'b0;
  logic       m_busy = 1'b0;
  logic       m_sclk = 1'b0;
  logic       m_cs_n = 1'b1;
  logic       m_din  = 1'b0;
  logic       s_pat  = 1'b0;
  logic [7:0] s_sh   = 8'h00;
  logic [3:0] s_cnt  = 4'h0;
  logic [7:0] s_in   = 8'h00;
  logic [7:0] got    = 8'h00;
  logic [7:0] got_q[$];

  // a released data line toggles so no stale level is seen
  assign pin_in = '{sclk: m_sclk, cs_n: m_cs_n,
                    din: m_mode ? m_din :
                         (pin_out.cs_n ? s_pat : s_sh[7])};

  always @(posedge mclk) begin
    s_pat <= ~s_pat;
    if (!m_busy) begin
      m_din <= ~m_din;
    end
  end

  always @(negedge pin_out.cs_n) begin
    s_sh = send_byte;
    s_cnt = 4'h0;
  end

  always @(posedge pin_out.sclk) begin
    s_in = {s_in[6:0], pin_out.dout};
  end

  // reload every eight bits so back-to-back bytes stay framed
  always @(negedge pin_out.sclk) begin
    s_cnt = s_cnt + 4'h1;
    s_sh = {s_sh[6:0], 1'b0};
    if (s_cnt == 4'h8) begin
      got_q.push_back(s_in);
      s_sh = send_byte;
      s_cnt = 4'h0;
    end
  end

  // drives a frame of n bits; n below 8 makes an early deselect
  task automatic xfer(input logic [7:0] b, input int n, input int half);
    logic [7:0] sb;
    sb = b;
    got = 8'h00;
    m_mode <= 1'b1;
    m_busy <= 1'b1;
    @(posedge mclk);
    m_cs_n <= 1'b0;
    m_din <= sb[7];
    for (int i = 0; i < n; i++) begin
      repeat (half) @(posedge mclk);
      got = {got[6:0], pin_out.dout};
      m_sclk <= 1'b1;
      repeat (half) @(posedge mclk);
      sb = sb << 1;
      m_sclk <= 1'b0;
      m_din <= sb[7];
    end
    repeat (half) @(posedge mclk);
    m_cs_n <= 1'b1;
    @(posedge mclk);
    m_busy <= 1'b0;
  endtask
endmodule

// >>> tb/spi_fifo_status_and_baud_test.sv
// spi_fifo_status_and_baud_test: register and pin tests of the spi block
// assumes the peer model on the pins and the register map of spi_pkg
`timescale 1ns/10ps
module spi_fifo_status_and_baud_test;
  logic              mclk       = 1'b0;
  logic              resetn     = 1'b0;
  spi_pkg::reg_req_t req        = '0;
  logic [15:0]       rdata;
  spi_pkg::pin_in_t  pin_in;
  spi_pkg::pin_out_t pin_out;
  logic              sclk_q     = 1'b0;
  int                fail_count = 0;
  int                cmp_count  = 0;
  int                t_rise     = 0;
  int                period     = 0;
  int                cyc        = 0;

  always #2 mclk = ~mclk;

  spi_fifo_status_and_baud u_spi_fifo_status_and_baud (
    .mclk    (mclk),
    .resetn  (resetn),
    .req     (req),
    .rdata   (rdata),
    .pin_in  (pin_in),
    .pin_out (pin_out)
  );

  spi_peer_model u_spi_peer_model (
    .mclk      (mclk),
    .send_byte (8'ha5),
    .pin_out   (pin_out),
    .pin_in    (pin_in)
  );

  // cycles between serial clock rises
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    sclk_q <= pin_out.sclk;
    if (pin_out.sclk && !sclk_q) begin
      period <= cyc - t_rise;
      t_rise <= cyc;
    end
  end

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic check(input string nm, input logic [15:0] e,
                       input logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [31:0] a, input logic [15:0] v);
    @(posedge mclk);
    req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge mclk);
    req.wr <= 1'b0;
  endtask

  task automatic rd(input logic [31:0] a, input logic [15:0] e,
                    input string nm);
    @(posedge mclk);
    req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge mclk);
    req.rd <= 1'b0;
    @(posedge mclk);
    check(nm, e, rdata);
  endtask

  task automatic wait_cs(input logic v);
    int n;
    n = 0;
    while (pin_out.cs_n !== v && n < 2000) begin
      @(posedge mclk);
      n++;
    end
    if (n == 2000) begin
      fail_count++;
      final_report();
    end
  endtask

  initial begin
    repeat (16) @(posedge mclk);
    resetn <= 1'b1;
    rd(spi_pkg::addr_status, 16'h0000, "status");
    rd(spi_pkg::addr_rx, 16'h0000, "rx empty");
    rd(32'h4000_4020, 16'h0000, "unmapped");
    wr(spi_pkg::addr_div, 16'h00ff);
    rd(spi_pkg::addr_div, 16'h00bf, "div");
    for (int i = 1; i <= 5; i++) begin
      wr(spi_pkg::addr_tx, 16'(8'h11 * i));
      rd(spi_pkg::addr_status, 16'((i > 4 ? 4 : i) * 2), "fill");
    end
    rd(spi_pkg::addr_tx, 16'h0000, "tx read");
    rd(spi_pkg::addr_status, 16'h0008, "tx kept");
    wr(spi_pkg::addr_div, 16'h0002);
    wr(spi_pkg::addr_cfg, 16'h0003);
    wait_cs(1'b0);
    check("master oe", 16'h0007,
          16'({pin_out.sclk_oe, pin_out.cs_n_oe, pin_out.dout_oe}));
    rd(spi_pkg::addr_status, 16'h0006, "master fill");
    wait_cs(1'b1);
    check("sclk period", 16'h0006, 16'(period));
    for (int i = 0; i < 4; i++) begin
      check("sent", 16'(8'h22 + 8'h11 * i),
            16'(u_spi_peer_model.got_q[i]));
      rd(spi_pkg::addr_rx, 16'h00a5, "rx byte");
    end
    rd(spi_pkg::addr_rx, 16'h0000, "rx drained");
    rd(spi_pkg::addr_status, 16'h0000, "master done");
    wr(spi_pkg::addr_div, 16'h003f);
    wr(spi_pkg::addr_cfg, 16'h0001);
    wr(spi_pkg::addr_tx, 16'h003c);
    rd(spi_pkg::addr_status, 16'h0002, "slave fill");
    fork
      u_spi_peer_model.xfer(8'h96, 8, 3);
      begin
        repeat (20) @(posedge mclk);
        check("slave oe", 16'h0001,
              16'({pin_out.sclk_oe, pin_out.cs_n_oe, pin_out.dout_oe}));
        rd(spi_pkg::addr_status, 16'h0002, "fill held");
      end
    join
    check("slave sent", 16'h003c, 16'(u_spi_peer_model.got));
    rd(spi_pkg::addr_status, 16'h0100, "slave done");
    rd(spi_pkg::addr_rx, 16'h0096, "slave rx");
    u_spi_peer_model.xfer(8'h5a, 8, 2);
    check("zeros", 16'h0000, 16'(u_spi_peer_model.got));
    rd(spi_pkg::addr_status, 16'h0111, "underrun");
    rd(spi_pkg::addr_status, 16'h0100, "cleared");
    rd(spi_pkg::addr_rx, 16'h005a, "rx");
    wr(spi_pkg::addr_cfg, 16'h2001);
    rd(spi_pkg::addr_cfg, 16'h2001, "cfg");
    wr(spi_pkg::addr_tx, 16'h0077);
    u_spi_peer_model.xfer(8'h5a, 8, 2);
    rd(spi_pkg::addr_status, 16'h0110, "flush");
    rd(spi_pkg::addr_rx, 16'h005a, "rx");
    wr(spi_pkg::addr_cfg, 16'h0001);
    wr(spi_pkg::addr_div, 16'h0000);
    wr(spi_pkg::addr_tx, 16'h00c3);
    u_spi_peer_model.xfer(8'hf0, 4, 2);
    rd(spi_pkg::addr_status, 16'h1003, "abort");
    u_spi_peer_model.xfer(8'h50, 4, 2);
    check("rest", 16'h0003, 16'(u_spi_peer_model.got));
    rd(spi_pkg::addr_rx, 16'h00f5, "resumed");
    rd(spi_pkg::addr_status, 16'h0000, "no abort");
    wr(spi_pkg::addr_div, 16'h0080);
    wr(spi_pkg::addr_tx, 16'h0081);
    u_spi_peer_model.xfer(8'hf0, 4, 2);
    rd(spi_pkg::addr_status, 16'h1001, "abort rst");
    wr(spi_pkg::addr_cfg, 16'h0000);
    wr(spi_pkg::addr_cfg, 16'h0001);
    u_spi_peer_model.xfer(8'ha5, 8, 2);
    rd(spi_pkg::addr_rx, 16'h00a5, "fresh frame");
    rd(spi_pkg::addr_status, 16'h0011, "dropped");
    final_report();
  end
endmodule
